// [hdl/timer_ch3_pkg.sv]
// Package with register map, field layout and reset values of the block.
`default_nettype none
package timer_ch3_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets on the Wishbone bus.
  // ------------------------------------------------------------------
  localparam logic [7:0] io_control_low_ch3_addr = 8'h00;
  localparam logic [7:0] timer_mode_register_ch3_addr = 8'h04;
  localparam logic [7:0] counter_ch3_addr = 8'h08;
  localparam logic [7:0] general_register_c_ch3_addr = 8'h0C;
  localparam logic [7:0] status_ch3_addr = 8'h10;
  localparam int addr_msb = 7;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int pin_function_select_bit3 = 3;
  localparam int pin_function_select_bit2 = 2;
  localparam int pin_function_select_bit1 = 1;
  localparam int pin_function_select_bit0 = 0;
  localparam int select_width = 4;
  localparam int buffer_mode_a_enable_pos = 0;
  localparam int counter_run_pos = 1;
  localparam int status_pin_level_pos = 0;
  localparam int status_compare_flag_pos = 1;
  localparam int status_capture_flag_pos = 2;

  // ------------------------------------------------------------------
  // Reset values and output action codes.
  // ------------------------------------------------------------------
  localparam logic [3:0] select_reset = 4'h0;
  localparam logic pin_reset = 1'b0;
  localparam logic [1:0] action_retain = 2'h0;
  localparam logic [1:0] action_low = 2'h1;
  localparam logic [1:0] action_high = 2'h2;
  localparam logic [1:0] action_toggle = 2'h3;
endpackage
`default_nettype wire

// [hdl/pin_edge_sync.sv]
// Two-flop synchroniser with rising and falling edge detection for a pin.
`default_nettype none
module pin_edge_sync (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta;
  logic stable;
  logic last;

  // ------------------------------------------------------------------
  // Synchroniser; the first flop feeds only the second one.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_in;
      stable <= meta;
      last <= stable;
    end
  end

  // Edges are taken between two settled samples, so glitches on the
  // metastable stage never reach the capture logic.
  assign level_out = stable;
  assign rise_out = stable & ~last;
  assign fall_out = ~stable & last;
endmodule
`default_nettype wire

// [hdl/timer_ch3_pin_c_io_control.sv]
// Channel 3 general register C with capture/compare pin C control.
//
// Summary of operation
// - Select bit3 zero: compare mode; 0001/0101 drive 0 at match, initial 0/1.
// - Codes 0010/0110 drive 1 at match, initial level 0/1.
// - Codes 0011/0111 toggle at every match, initial level 0/1.
// - Bit3 one, low bits 00: capture on rising pin edge.
// - Bit3 one, low bits 01: capture on falling pin edge.
// - Bit3 one, bit1 one: capture on both pin edges.
// - After reset the pin drives 0 until the select field is written.
// - Buffer mode set: no capture and no compare action at all.
`default_nettype none
module timer_ch3_pin_c_io_control #(
  parameter int counter_width = 16
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic capture_compare_pin_c_ch3_in,
  output logic capture_compare_pin_c_ch3_out,
  output logic capture_compare_pin_c_ch3_oe_out,
  output logic compare_match_out,
  output logic capture_strobe_out
);
  // ------------------------------------------------------------------
  // Parameter check.
  // ------------------------------------------------------------------
  if (counter_width < 2 || counter_width > 32) begin : g_bad_width
    $error("counter_width must lie between 2 and 32");
  end

  logic [3:0] pin_select;
  logic buffer_mode_a_enable;
  logic counter_run;
  logic [counter_width-1:0] counter;
  logic [counter_width-1:0] general_register_c_ch3;
  logic compare_flag;
  logic capture_flag;
  logic pin_level;
  logic pin_sync;
  logic pin_rise;
  logic pin_fall;
  logic bus_req;
  logic bus_write;
  logic compare_mode;
  logic match;
  logic capture;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------------
  // Pin level that a compare match produces for a given select code.
  function automatic logic match_level(input logic [3:0] sel,
                                       input logic now);
    logic [1:0] act;
    act = sel[timer_ch3_pkg::pin_function_select_bit1:
              timer_ch3_pkg::pin_function_select_bit0];
    case (act)
      timer_ch3_pkg::action_low: match_level = 1'b0;
      timer_ch3_pkg::action_high: match_level = 1'b1;
      timer_ch3_pkg::action_toggle: match_level = ~now;
      default: match_level = now;
    endcase
  endfunction

  // Merges write data into a register under the byte lane enables.
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // ------------------------------------------------------------------
  // Pin input synchroniser.
  // ------------------------------------------------------------------
  pin_edge_sync u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_in(capture_compare_pin_c_ch3_in),
    .level_out(pin_sync),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // ------------------------------------------------------------------
  // Bus decode and event conditions.
  // ------------------------------------------------------------------
  // A write lands on the edge at which the master sees ack high.
  assign bus_req = wb_cyc_in & wb_stb_in;
  assign bus_write = bus_req & wb_we_in & wb_ack_out;
  assign compare_mode =
    ~pin_select[timer_ch3_pkg::pin_function_select_bit3];
  assign match = compare_mode & ~buffer_mode_a_enable & counter_run &
                 (counter == general_register_c_ch3);
  // Bit 1 set means both edges, otherwise bit 0 picks the edge.
  assign capture = ~compare_mode & ~buffer_mode_a_enable &
    (pin_select[timer_ch3_pkg::pin_function_select_bit1] ?
       (pin_rise | pin_fall) :
     pin_select[timer_ch3_pkg::pin_function_select_bit0] ?
       pin_fall :
     pin_rise);

  // ------------------------------------------------------------------
  // Register writes and mode control.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_select <= timer_ch3_pkg::select_reset;
      buffer_mode_a_enable <= 1'b0;
      counter_run <= 1'b0;
    end else if (bus_write && wb_sel_in[0]) begin
      if (wb_adr_in == timer_ch3_pkg::io_control_low_ch3_addr) begin
        pin_select <= wb_dat_in[timer_ch3_pkg::select_width-1:0];
      end
      if (wb_adr_in == timer_ch3_pkg::timer_mode_register_ch3_addr) begin
        buffer_mode_a_enable <=
          wb_dat_in[timer_ch3_pkg::buffer_mode_a_enable_pos];
        counter_run <= wb_dat_in[timer_ch3_pkg::counter_run_pos];
      end
    end
  end

  // ------------------------------------------------------------------
  // Channel counter; a software write wins over counting.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      counter <= '0;
    end else if (bus_write &&
                 wb_adr_in == timer_ch3_pkg::counter_ch3_addr) begin
      counter <= counter_width'(lane_merge(32'(counter), wb_dat_in,
                                           wb_sel_in));
    end else if (counter_run) begin
      counter <= counter + 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // General register; a capture wins over a software write so that a
  // pin event is never lost.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      general_register_c_ch3 <= '0;
    end else if (capture) begin
      general_register_c_ch3 <= counter;
    end else if (bus_write &&
        wb_adr_in == timer_ch3_pkg::general_register_c_ch3_addr) begin
      general_register_c_ch3 <= counter_width'(lane_merge(
        32'(general_register_c_ch3), wb_dat_in, wb_sel_in));
    end
  end

  // ------------------------------------------------------------------
  // Pin output level. Writing a compare code with an action loads its
  // initial level; a match in the same cycle yields to that write.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_level <= timer_ch3_pkg::pin_reset;
    end else if (bus_write && wb_sel_in[0] &&
                 wb_adr_in == timer_ch3_pkg::io_control_low_ch3_addr) begin
      if (!wb_dat_in[timer_ch3_pkg::pin_function_select_bit3] &&
          wb_dat_in[timer_ch3_pkg::pin_function_select_bit1:
                    timer_ch3_pkg::pin_function_select_bit0]
            != timer_ch3_pkg::action_retain) begin
        pin_level <=
          wb_dat_in[timer_ch3_pkg::pin_function_select_bit2];
      end
    end else if (match) begin
      pin_level <= match_level(pin_select, pin_level);
    end
  end

  // ------------------------------------------------------------------
  // Pin drive and event pulses, all from flops.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      capture_compare_pin_c_ch3_out <= timer_ch3_pkg::pin_reset;
      capture_compare_pin_c_ch3_oe_out <= 1'b1;
      compare_match_out <= 1'b0;
      capture_strobe_out <= 1'b0;
    end else begin
      capture_compare_pin_c_ch3_out <= pin_level;
      capture_compare_pin_c_ch3_oe_out <= compare_mode;
      compare_match_out <= match;
      capture_strobe_out <= capture;
    end
  end

  // ------------------------------------------------------------------
  // Sticky status flags; writing one clears, but a new event wins.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      compare_flag <= 1'b0;
      capture_flag <= 1'b0;
    end else begin
      if (match) begin
        compare_flag <= 1'b1;
      end else if (bus_write && wb_sel_in[0] &&
                   wb_adr_in == timer_ch3_pkg::status_ch3_addr &&
                   wb_dat_in[timer_ch3_pkg::status_compare_flag_pos]) begin
        compare_flag <= 1'b0;
      end
      if (capture) begin
        capture_flag <= 1'b1;
      end else if (bus_write && wb_sel_in[0] &&
                   wb_adr_in == timer_ch3_pkg::status_ch3_addr &&
                   wb_dat_in[timer_ch3_pkg::status_capture_flag_pos]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read mux; unmapped addresses read zero and are still acknowledged.
  // ------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_in)
      timer_ch3_pkg::io_control_low_ch3_addr:
        next_rdata[timer_ch3_pkg::select_width-1:0] = pin_select;
      timer_ch3_pkg::timer_mode_register_ch3_addr: begin
        next_rdata[timer_ch3_pkg::buffer_mode_a_enable_pos] =
          buffer_mode_a_enable;
        next_rdata[timer_ch3_pkg::counter_run_pos] = counter_run;
      end
      timer_ch3_pkg::counter_ch3_addr:
        next_rdata = 32'(counter);
      timer_ch3_pkg::general_register_c_ch3_addr:
        next_rdata = 32'(general_register_c_ch3);
      timer_ch3_pkg::status_ch3_addr: begin
        next_rdata[timer_ch3_pkg::status_pin_level_pos] = pin_sync;
        next_rdata[timer_ch3_pkg::status_compare_flag_pos] = compare_flag;
        next_rdata[timer_ch3_pkg::status_capture_flag_pos] = capture_flag;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // Wishbone answer: ack one cycle after the request, dropped after one.
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= bus_req & ~wb_ack_out;
      if (bus_req && !wb_ack_out) begin
        wb_dat_out <= next_rdata;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/pin_ctl_props.sv]
// Port-level checks for the channel 3 pin C control block.
`default_nettype none
module pin_ctl_props (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic wb_ack_out,
  input wire logic capture_compare_pin_c_ch3_out,
  input wire logic capture_compare_pin_c_ch3_oe_out,
  input wire logic compare_match_out,
  input wire logic capture_strobe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] ctl;
  logic buf_on;
  logic written;
  logic [1:0] age;
  logic wr;
  logic ctl_wr;
  logic mode_wr;
  logic pin;
  // A write lands at the edge where the master sees ack high.
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
  assign ctl_wr = wr && wb_sel_in[0] && wb_adr_in == 8'h00;
  assign mode_wr = wr && wb_sel_in[0] && wb_adr_in == 8'h04;
  assign pin = capture_compare_pin_c_ch3_out;
  // Shadow copies; age gives registered outputs time to follow a change.
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctl <= 4'h0;
      buf_on <= 1'b0;
      written <= 1'b0;
      age <= 2'h3;
    end else begin
      if (ctl_wr) begin
        ctl <= wb_dat_in[3:0];
        written <= 1'b1;
      end
      if (mode_wr) begin
        buf_on <= wb_dat_in[0];
      end
      age <= ctl_wr ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out &&
    !$past(wb_ack_out) |=> wb_ack_out) else $error("ack late");
  reset_pin_a: assert property (!written |-> !pin &&
    capture_compare_pin_c_ch3_oe_out) else $error("pin not low after reset");
  oe_mode_a: assert property (age == 2'h3 |->
    capture_compare_pin_c_ch3_oe_out == !ctl[3]) else $error("oe wrong");
  init_level_a: assert property (
    ctl_wr && !wb_dat_in[3] && wb_dat_in[1:0] != 2'h0 |=> ##[0:2] pin == ctl[2])
    else $error("initial level wrong");
  // The match pulse leads the pin by one edge, so the pin is checked next.
  drive_low_a: assert property (compare_match_out && ctl == 4'h1 ||
    compare_match_out && ctl == 4'h5 |=> !pin) else $error("pin not low");
  drive_high_a: assert property (compare_match_out && !ctl[3] &&
    ctl[1:0] == 2'h2 |=> pin) else $error("pin not high");
  toggle_out_a: assert property (compare_match_out && !ctl[3] &&
    ctl[1:0] == 2'h3 |=> pin != $past(pin)) else $error("no toggle");
  retain_out_a: assert property (compare_match_out && !ctl[3] &&
    ctl[1:0] == 2'h0 |=> $stable(pin)) else $error("pin not retained");
  buffer_quiet_a: assert property (compare_match_out ||
    capture_strobe_out |-> !buf_on) else $error("event in buffer mode");
  capture_mode_a: assert property (capture_strobe_out |-> ctl[3])
    else $error("capture outside capture mode");
  cover property (compare_match_out && ctl[1:0] == 2'h3);
  cover property (capture_strobe_out && ctl[1]);
  cover property (ctl_wr && wb_dat_in[3]);
endmodule
`default_nettype wire

// [tb/pin_board.sv]
// Board-side model of the capture/compare pin C line.
`default_nettype none
module pin_board (
  input wire logic oe_in,
  input wire logic level_in,
  input wire logic drive_in,
  output logic wire_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // The board source only drives while the block has let go of the line.
  assign wire_out = oe_in ? level_in : drive_in;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the channel 3 pin C control block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, cyc, stb, we, drive, pin, pin_out, oe, match, strobe, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic lvl;
  int num_errors, comparisons;
  logic [3:0] codes [8] = '{4'h1, 4'h5, 4'h2, 4'h6, 4'h3, 4'h7, 4'h0, 4'h4};
  logic [3:0] caps [8] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hB, 4'hF};
  timer_ch3_pin_c_io_control dut (.sys_clk_in(clk), .sys_rst_in(rst),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .capture_compare_pin_c_ch3_in(pin),
    .capture_compare_pin_c_ch3_out(pin_out),
    .capture_compare_pin_c_ch3_oe_out(oe), .compare_match_out(match),
    .capture_strobe_out(strobe));
  pin_board board (.oe_in(oe), .level_in(pin_out), .drive_in(drive),
    .wire_out(pin));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stands until ack is seen high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // Only the watchdog ends a wait that never sees ack.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  // Counts pin events; compare pulses only matter while the pin is driven.
  task automatic events(input int k, output int m);
    m = 0;
    repeat (k) begin
      @(posedge clk);
      if (match === 1'b1 && oe === 1'b1 || strobe === 1'b1) m++;
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Watchdog sized well above the whole sequence.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    int m;
    {rst, cyc, stb, we, drive, adr, dat} = {5'h10, 8'h0, 32'h0};
    sel = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({31'h0, pin_out}, 32'h0);
    check({31'h0, oe}, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'hFC, 32'h0);
    $display("test reset done");
    wr(8'h0C, 32'h40);
    lvl = 1'b0;
    foreach (codes[i]) begin
      wr(8'h00, {28'h0, codes[i]});
      if (codes[i][1:0] != 2'h0) lvl = codes[i][2];
      repeat (3) @(posedge clk);
      check({31'h0, pin_out}, {31'h0, lvl});
      repeat (2) begin
        wr(8'h08, 32'h3C);
        wr(8'h04, 32'h2);
        m = 0;
        while (match !== 1'b1 && m < 40) begin
          @(posedge clk);
          m++;
        end
        check({31'h0, match}, 32'h1);
        // The pin follows one edge after the match pulse.
        @(posedge clk);
        case (codes[i][1:0])
          2'h1: lvl = 1'b0;
          2'h2: lvl = 1'b1;
          2'h3: lvl = ~lvl;
          default: lvl = lvl;
        endcase
        check({31'h0, pin_out}, {31'h0, lvl});
        wr(8'h04, 32'h0);
      end
    end
    $display("test compare done");
    wr(8'h08, 32'h1234);
    wr(8'h00, 32'h8);
    // Let the released line settle low first so that the rise is real.
    repeat (4) @(posedge clk);
    drive <= 1'b1;
    repeat (8) @(posedge clk);
    rd(8'h0C, 32'h1234);
    drive <= 1'b0;
    wr(8'h04, 32'h2);
    foreach (caps[i]) begin
      wr(8'h00, {28'h0, caps[i]});
      drive <= 1'b1;
      events(12, m);
      check(m, {31'h0, caps[i][1] | ~caps[i][0]});
      drive <= 1'b0;
      events(12, m);
      check(m, {31'h0, caps[i][1] | caps[i][0]});
      check({31'h0, oe}, 32'h0);
    end
    $display("test capture done");
    wr(8'h04, 32'h1);
    drive <= 1'b1;
    events(12, m);
    check(m, 32'h0);
    wr(8'h00, 32'h3);
    wr(8'h0C, 32'h40);
    wr(8'h08, 32'h3C);
    wr(8'h04, 32'h3);
    events(16, m);
    check(m, 32'h0);
    check({31'h0, pin_out}, 32'h0);
    $display("test buffer done");
    summarize();
  end
endmodule
bind timer_ch3_pin_c_io_control pin_ctl_props chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
  .capture_compare_pin_c_ch3_out(capture_compare_pin_c_ch3_out),
  .capture_compare_pin_c_ch3_oe_out(capture_compare_pin_c_ch3_oe_out),
  .compare_match_out(compare_match_out),
  .capture_strobe_out(capture_strobe_out));
`default_nettype wire
